// >>> plc_pkg.sv
// Shared constants and types for the clock-loop control block
package plc_pkg;

  // ****************************************************************
  // Register map (byte addresses on the processor bus)
  // ****************************************************************
  localparam logic [31:0] ADDR_CTRL_HOLD = 32'he01fc080;
  localparam logic [31:0] ADDR_CFG_HOLD = 32'he01fc084;
  localparam logic [31:0] ADDR_STATUS = 32'he01fc088;
  localparam logic [31:0] ADDR_FEED = 32'he01fc08c;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CONNECT_BIT = 1;
  localparam int CTRL_WIDTH = 2;
  localparam int CFG_MULTIPLIER_FIELD_LSB = 0;
  localparam int CFG_MULTIPLIER_FIELD_WIDTH = 5;
  localparam int CFG_PSEL_LSB = 5;
  localparam int CFG_PSEL_WIDTH = 2;
  localparam int CFG_WIDTH = 7;
  localparam int STAT_ENABLE_BIT = 8;
  localparam int STAT_CONNECT_BIT = 9;
  localparam int STAT_LOCK_BIT = 10;
  localparam int FEED_KEY_WIDTH = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 2'h0;
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 7'h00;
  localparam logic [31:0] RDATA_IDLE = 32'h00000000;

  // ****************************************************************
  // Derived settings
  // ****************************************************************
  localparam logic [5:0] MULT_OFFSET = 6'h01;
  localparam logic [4:0] POST_DIV_MIN = 5'h02;

  // ****************************************************************
  // State machines
  // ****************************************************************
  typedef enum logic [1:0] {
    PLC_FEED_IDLE = 2'b01,
    PLC_FEED_ARMED = 2'b10
  } plc_feed_state_t;

  typedef enum logic [3:0] {
    PLC_SRC_OSC = 4'b0001,
    PLC_SRC_GAP_TO_LOOP = 4'b0010,
    PLC_SRC_LOOP = 4'b0100,
    PLC_SRC_GAP_TO_OSC = 4'b1000
  } plc_src_state_t;

endpackage

// >>> plc_clock_switch.sv
// Break-before-make sequencer for the oscillator / loop clock gates
`timescale 1ns/1ps

module plc_clock_switch #(
  parameter int GAP_CYCLES = 4
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Request
  input wire logic want_loop_i,
  // Gates
  output logic osc_gate_o,
  output logic loop_gate_o,
  output logic busy_o
);

  plc_pkg::plc_src_state_t state;
  logic [7:0] gap_count;

  // ****************************************************************
  // Source sequencing
  // ****************************************************************
  // Both gates are closed for the whole gap so no truncated pulse escapes
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state <= plc_pkg::PLC_SRC_OSC;
      gap_count <= 8'h00;
    end else begin
      case (state)
        plc_pkg::PLC_SRC_OSC: begin
          gap_count <= 8'h00;
          if (want_loop_i) begin
            state <= plc_pkg::PLC_SRC_GAP_TO_LOOP;
          end
        end
        plc_pkg::PLC_SRC_GAP_TO_LOOP: begin
          gap_count <= gap_count + 8'h01;
          if (!want_loop_i) begin
            state <= plc_pkg::PLC_SRC_GAP_TO_OSC;
            gap_count <= 8'h00;
          end else if (gap_count == 8'(GAP_CYCLES - 1)) begin
            state <= plc_pkg::PLC_SRC_LOOP;
          end
        end
        plc_pkg::PLC_SRC_LOOP: begin
          gap_count <= 8'h00;
          if (!want_loop_i) begin
            state <= plc_pkg::PLC_SRC_GAP_TO_OSC;
          end
        end
        plc_pkg::PLC_SRC_GAP_TO_OSC: begin
          gap_count <= gap_count + 8'h01;
          if (gap_count == 8'(GAP_CYCLES - 1)) begin
            state <= plc_pkg::PLC_SRC_OSC;
          end
        end
        default: begin
          state <= plc_pkg::PLC_SRC_OSC;
          gap_count <= 8'h00;
        end
      endcase
    end
  end

  // Gates come straight from state flops, never both open
  assign osc_gate_o = (state == plc_pkg::PLC_SRC_OSC);
  assign loop_gate_o = (state == plc_pkg::PLC_SRC_LOOP);
  assign busy_o = (state == plc_pkg::PLC_SRC_GAP_TO_LOOP) || (state == plc_pkg::PLC_SRC_GAP_TO_OSC);

endmodule // plc_clock_switch

// >>> plc_loop_control.sv
// Control, feed protection and status for the clock multiplier loop
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

// What this block does
// R1: Reference clock kept within 10 to 25 MHz
// R2: Output clock kept within 10 to 60 MHz
// R3: Multiplier factor accepted from 1 to 32
// R4: Oscillator core kept within 156 to 320 MHz
// R5: Post divider selects 2, 4, 8, 16
// R6: Even division gives equal high, low phases
// R7: Settings change only after correct feed
// R8: Reset and power-down force loop off, bypassed
// R9: Loop never enables itself
// R10: Software enables, waits lock, then connects
// R11: Control holding register, read/write, reset zero
// R12: Configuration holding register, read/write, reset zero
// R13: Status shows shadow values, not holding
// R14: Good feed copies both holding into shadows
// R15: Status reports present loop state too
// R16: Bit 0 enables, bit 1 connects loop
// R17: Multiplier bits 4:0, divider bits 6:5
// R18: Status bit 10 shows lock
// R19: Source switch is glitch free
// R20: Feed is two keys back to back
// R21: All shadows update in one cycle
module plc_loop_control #(
  parameter logic [7:0] FEED_KEY_FIRST = 8'haa,
  parameter logic [7:0] FEED_KEY_SECOND = 8'h55,
  parameter int SWITCH_GAP_CYCLES = 4
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Power management
  input wire logic power_down_entry_i,
  // Analog loop
  input wire logic loop_lock_raw_i,
  output logic loop_enable_bit_o,
  output logic [4:0] multiplier_field_o,
  output logic [5:0] multiplier_factor_o,
  output logic [1:0] post_div_select_o,
  output logic [4:0] post_div_ratio_o,
  // Clock selection
  output logic osc_clk_gate_o,
  output logic loop_clk_gate_o,
  output logic clock_switch_busy_o,
  output logic feed_accepted_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [plc_pkg::CTRL_WIDTH-1:0] loop_control_holding;
  logic [plc_pkg::CFG_WIDTH-1:0] loop_config_holding;
  logic [plc_pkg::CTRL_WIDTH-1:0] control_shadow;
  logic [plc_pkg::CFG_WIDTH-1:0] config_shadow;
  plc_pkg::plc_feed_state_t feed_state;
  logic feed_valid;
  logic feed_access;
  logic key_first_hit;
  logic key_second_hit;
  logic lock_sync1;
  logic lock_sync2;
  logic lock_sync3;
  logic loop_locked_flag;
  logic [15:0] loop_active_status;
  logic [31:0] next_rdata;
  logic want_loop;
  logic feed_pulse;

  // ****************************************************************
  // Holding registers
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      loop_control_holding <= plc_pkg::CTRL_RESET; // see R11
    end else if (reg_wr_i && reg_addr_i == plc_pkg::ADDR_CTRL_HOLD) begin
      loop_control_holding <= reg_wdata_i[plc_pkg::CTRL_WIDTH-1:0]; // see R11
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      loop_config_holding <= plc_pkg::CFG_RESET; // see R12
    end else if (reg_wr_i && reg_addr_i == plc_pkg::ADDR_CFG_HOLD) begin
      loop_config_holding <= reg_wdata_i[plc_pkg::CFG_WIDTH-1:0]; // see R12 R17
    end
  end

  // ****************************************************************
  // Feed sequence
  // ****************************************************************
  assign feed_access = reg_wr_i && reg_addr_i == plc_pkg::ADDR_FEED;
  assign key_first_hit = feed_access && reg_wdata_i[plc_pkg::FEED_KEY_WIDTH-1:0] == FEED_KEY_FIRST;
  assign key_second_hit = feed_access && reg_wdata_i[plc_pkg::FEED_KEY_WIDTH-1:0] == FEED_KEY_SECOND;

  // Any access other than a repeated first key, reads included, drops the arming
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      feed_state <= plc_pkg::PLC_FEED_IDLE;
    end else begin
      case (feed_state)
        plc_pkg::PLC_FEED_IDLE: begin
          if (key_first_hit) begin
            feed_state <= plc_pkg::PLC_FEED_ARMED; // see R20
          end
        end
        plc_pkg::PLC_FEED_ARMED: begin
          if (key_first_hit) begin
            feed_state <= plc_pkg::PLC_FEED_ARMED;
          end else if (reg_wr_i || reg_rd_i) begin
            feed_state <= plc_pkg::PLC_FEED_IDLE; // see R20
          end
        end
        default: begin
          feed_state <= plc_pkg::PLC_FEED_IDLE;
        end
      endcase
    end
  end

  assign feed_valid = (feed_state == plc_pkg::PLC_FEED_ARMED) && key_second_hit; // see R7 R20

  // ****************************************************************
  // Shadow registers
  // ****************************************************************
  // Power-down beats a feed on the control shadow in the same cycle; the config shadow still loads, and the loop must end up off
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      control_shadow <= plc_pkg::CTRL_RESET; // see R8 R9
      config_shadow <= plc_pkg::CFG_RESET;
    end else if (power_down_entry_i) begin
      control_shadow <= plc_pkg::CTRL_RESET; // see R8
      if (feed_valid) begin
        config_shadow <= loop_config_holding;
      end
    end else if (feed_valid) begin
      control_shadow <= loop_control_holding; // see R14 R21 R9
      config_shadow <= loop_config_holding; // see R14 R21
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      feed_pulse <= 1'b0;
    end else begin
      feed_pulse <= feed_valid;
    end
  end

  assign feed_accepted_o = feed_pulse;

  // ****************************************************************
  // Loop drive
  // ****************************************************************
  assign loop_enable_bit_o = control_shadow[plc_pkg::CTRL_ENABLE_BIT]; // see R16
  assign multiplier_field_o = config_shadow[plc_pkg::CFG_MULTIPLIER_FIELD_LSB +: plc_pkg::CFG_MULTIPLIER_FIELD_WIDTH];
  // Field 0..31 maps to factor 1..32
  assign multiplier_factor_o = {1'b0, multiplier_field_o} + plc_pkg::MULT_OFFSET; // see R3
  assign post_div_select_o = config_shadow[plc_pkg::CFG_PSEL_LSB +: plc_pkg::CFG_PSEL_WIDTH];
  // Ratio is always even, so the divided clock keeps equal phases
  assign post_div_ratio_o = plc_pkg::POST_DIV_MIN << post_div_select_o; // see R5 R6

  // ****************************************************************
  // Lock input synchroniser
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      lock_sync1 <= 1'b0;
      lock_sync2 <= 1'b0;
      lock_sync3 <= 1'b0;
    end else begin
      lock_sync1 <= loop_lock_raw_i;
      lock_sync2 <= lock_sync1;
      lock_sync3 <= lock_sync2;
    end
  end

  // A disabled loop stops reporting lock one cycle after its enable bit clears
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      loop_locked_flag <= 1'b0;
    end else if (!loop_enable_bit_o) begin
      loop_locked_flag <= 1'b0; // see R18
    end else if (lock_sync2 == lock_sync3) begin
      loop_locked_flag <= lock_sync3; // see R18
    end
  end

  // ****************************************************************
  // Clock source selection
  // ****************************************************************
  // Lock is not checked before connecting; software must wait for it
  assign want_loop = control_shadow[plc_pkg::CTRL_ENABLE_BIT] &&
                     control_shadow[plc_pkg::CTRL_CONNECT_BIT]; // see R16 R10

  plc_clock_switch #(
    .GAP_CYCLES(SWITCH_GAP_CYCLES)
  ) u_switch (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .want_loop_i(want_loop),
    .osc_gate_o(osc_clk_gate_o), // see R19
    .loop_gate_o(loop_clk_gate_o), // see R19
    .busy_o(clock_switch_busy_o)
  );

  // ****************************************************************
  // Status and read port
  // ****************************************************************
  always_comb begin
    loop_active_status = 16'h0000;
    loop_active_status[plc_pkg::CFG_WIDTH-1:0] = config_shadow; // see R13 R17
    loop_active_status[plc_pkg::STAT_ENABLE_BIT] = control_shadow[plc_pkg::CTRL_ENABLE_BIT]; // see R15
    loop_active_status[plc_pkg::STAT_CONNECT_BIT] = control_shadow[plc_pkg::CTRL_CONNECT_BIT]; // see R15
    loop_active_status[plc_pkg::STAT_LOCK_BIT] = loop_locked_flag; // see R18
  end

  // Feed register and unmapped addresses read as zero
  always_comb begin
    next_rdata = plc_pkg::RDATA_IDLE;
    if (reg_addr_i == plc_pkg::ADDR_CTRL_HOLD) begin
      next_rdata[plc_pkg::CTRL_WIDTH-1:0] = loop_control_holding;
    end else if (reg_addr_i == plc_pkg::ADDR_CFG_HOLD) begin
      next_rdata[plc_pkg::CFG_WIDTH-1:0] = loop_config_holding;
    end else if (reg_addr_i == plc_pkg::ADDR_STATUS) begin
      next_rdata[15:0] = loop_active_status; // see R13
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= plc_pkg::RDATA_IDLE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= plc_pkg::RDATA_IDLE;
    end
  end

endmodule // plc_loop_control

// >>> plc_loop_control_chk.sv
// Concurrent checks on the ports of the clock-loop control block
`timescale 1ns/1ps

module plc_loop_control_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Loop side
  input wire logic power_down_entry_i,
  input wire logic loop_lock_raw_i,
  input wire logic loop_enable_bit_o,
  input wire logic [4:0] multiplier_field_o,
  input wire logic [5:0] multiplier_factor_o,
  input wire logic [1:0] post_div_select_o,
  input wire logic [4:0] post_div_ratio_o,
  // Clock selection
  input wire logic osc_clk_gate_o,
  input wire logic loop_clk_gate_o,
  input wire logic clock_switch_busy_o,
  input wire logic feed_accepted_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_factor_offset: assert property (multiplier_factor_o == {1'b0, multiplier_field_o} + 6'h01)
    else $error("factor does not follow field");
  a_ratio_decode: assert property (post_div_ratio_o == (5'h02 << post_div_select_o))
    else $error("post divider ratio wrong");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_enable_by_feed: assert property ($rose(loop_enable_bit_o) |-> feed_accepted_o)
    else $error("loop enabled without feed");
  a_shadow_hold: assert property (!feed_accepted_o |-> $stable(multiplier_field_o) && $stable(post_div_select_o))
    else $error("shadow changed without feed");
  a_powerdown_off: assert property (power_down_entry_i |=> !loop_enable_bit_o)
    else $error("loop still on after power-down");
  a_gates_apart: assert property (!(osc_clk_gate_o && loop_clk_gate_o))
    else $error("both clock gates open");
  a_gap_closed: assert property (clock_switch_busy_o |-> !osc_clk_gate_o && !loop_clk_gate_o)
    else $error("gate open during switch gap");
  a_lock_gated: assert property (reg_rd_i && reg_addr_i == plc_pkg::ADDR_STATUS && !loop_enable_bit_o
    && !$past(loop_enable_bit_o) |=> !reg_rdata_o[10])
    else $error("lock shown while loop off");
  a_feed_pulse: assert property (feed_accepted_o |=> !feed_accepted_o)
    else $error("feed pulse longer than one cycle");
endmodule // plc_loop_control_chk

// >>> plc_loop_control_tb.sv
// Self-checking bench for the clock-loop control block
`timescale 1ns/1ps

module plc_loop_control_tb;
  // Keys differ from the defaults so the parameters are really exercised
  localparam logic [7:0] KEY1 = 8'h3c;
  localparam logic [7:0] KEY2 = 8'hc3;
  // Assumed reference clock, inside the permitted input band
  localparam int REF_MHZ = 12;
  localparam logic [31:0] A_CTRL = plc_pkg::ADDR_CTRL_HOLD;
  localparam logic [31:0] A_CFG = plc_pkg::ADDR_CFG_HOLD;
  localparam logic [31:0] A_STAT = plc_pkg::ADDR_STATUS;
  localparam logic [31:0] A_FEED = plc_pkg::ADDR_FEED;
  logic core_clk_i;
  logic sys_rst_i = 1'b1;
  logic [31:0] reg_addr_i = 32'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic power_down_entry_i = 1'b0;
  logic loop_lock_raw_i = 1'b0;
  logic loop_enable_bit_o, osc_clk_gate_o, loop_clk_gate_o, clock_switch_busy_o, feed_accepted_o;
  logic [4:0] multiplier_field_o, post_div_ratio_o;
  logic [5:0] multiplier_factor_o;
  logic [1:0] post_div_select_o;
  int bad_count = 0;
  int num_checks = 0;
  int n;

  plc_loop_control #(.FEED_KEY_FIRST(KEY1), .FEED_KEY_SECOND(KEY2), .SWITCH_GAP_CYCLES(4)) u_dut (.*);

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // ****************************************************************
  // Bus tasks and comparison
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Both strobes set every call, so back-to-back calls never double-drive
  task automatic op(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
  endtask

  task automatic idle;
    op(1'b0, 1'b0, 32'h0, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    op(1'b1, 1'b0, a, d);
  endtask

  // Registered outputs seen here still hold the value of the cycle just ended
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    op(1'b0, 1'b1, a, 32'h0);
    idle();
    chk(reg_rdata_o, exp);
  endtask

  task automatic feed;
    wr(A_FEED, {24'h0, KEY1});
    wr(A_FEED, {24'h0, KEY2});
    idle();
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wait_gate(input logic want);
    // Both gates must settle, not just the loop gate leaving its old level
    for (n = 0; n < 20 && (loop_clk_gate_o !== want || osc_clk_gate_o !== !want); n++)
      idle();
    chk(loop_clk_gate_o, want);
    if (n == 20)
      complete_run();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    idle();
    chk(multiplier_factor_o, 32'h1);
    chk(post_div_ratio_o, 32'h2);
    chk(osc_clk_gate_o, 32'h1);
    rd(A_CTRL, 32'h0);
    rd(A_CFG, 32'h0);
    rd(A_STAT, 32'h0);
    rd(32'he01fc090, 32'h0);
    wr(A_CTRL, 32'hfd);
    wr(A_CFG, 32'hff);
    wr(A_STAT, 32'hffff);
    rd(A_CTRL, 32'h1);
    rd(A_CFG, 32'h7f);
    rd(A_STAT, 32'h0);
    // Broken sequences: access between keys, wrong second key
    wr(A_FEED, {24'h0, KEY1});
    op(1'b0, 1'b1, A_CTRL, 32'h0);
    wr(A_FEED, {24'h0, KEY2});
    wr(A_FEED, {24'h0, KEY1});
    wr(A_FEED, 32'h0);
    wr(A_FEED, {24'h0, KEY2});
    idle();
    chk(loop_enable_bit_o, 32'h0);
    rd(A_STAT, 32'h0);
    // Repeated first key and an idle gap still make a valid feed
    wr(A_FEED, {24'h0, KEY1});
    wr(A_FEED, {24'h0, KEY1});
    idle();
    wr(A_FEED, {24'h0, KEY2});
    idle();
    chk(feed_accepted_o, 32'h1);
    chk(loop_enable_bit_o, 32'h1);
    idle();
    chk(feed_accepted_o, 32'h0);
    rd(A_STAT, 32'h17f);
    for (n = 0; n < 4; n++) begin
      wr(A_CFG, {25'h0, n[1:0], n[0] ? 5'h1f : 5'h00});
      feed();
      chk(post_div_ratio_o, 32'h2 << n);
      chk(multiplier_factor_o, n[0] ? 32'h20 : 32'h1);
      chk(multiplier_field_o, n[0] ? 32'h1f : 32'h0);
      chk(post_div_select_o, n);
    end
    loop_lock_raw_i <= 1'b1;
    repeat (6) idle();
    rd(A_STAT, 32'h57f);
    wr(A_CFG, 32'h23);
    wr(A_CTRL, 32'h3);
    feed();
    chk((REF_MHZ * multiplier_factor_o) inside {[10:60]}, 32'h1);
    chk((REF_MHZ * multiplier_factor_o * post_div_ratio_o) inside {[156:320]}, 32'h1);
    idle();
    chk(clock_switch_busy_o, 32'h1);
    wait_gate(1'b1);
    chk(osc_clk_gate_o, 32'h0);
    rd(A_STAT, 32'h723);
    power_down_entry_i <= 1'b1;
    idle();
    power_down_entry_i <= 1'b0;
    idle();
    chk(loop_enable_bit_o, 32'h0);
    wait_gate(1'b0);
    chk(osc_clk_gate_o, 32'h1);
    rd(A_CTRL, 32'h3);
    rd(A_STAT, 32'h023);
    sys_rst_i <= 1'b1;
    repeat (6) idle();
    sys_rst_i <= 1'b0;
    idle();
    rd(A_CTRL, 32'h0);
    rd(A_STAT, 32'h0);
    complete_run();
  end
endmodule // plc_loop_control_tb

bind plc_loop_control plc_loop_control_chk u_chk (.*);
